// [verilog/mpcd_pkg.sv]
// mpcd_pkg: shared constants and types for the motor parameter code decoder
// assumes: a single 10 MHz core clock, codes arrive as plain 7-bit inputs
package mpcd_pkg;

   // ------------------------------------------------------------
   // code field layout
   // ------------------------------------------------------------
   localparam int CODE_W = 7;
   localparam int MANT_LSB = 0;
   localparam int MANT_MSB = 3;
   localparam int EXP_LSB = 4;
   localparam int EXP_MSB = 6;
   localparam int LIN_W = 11;
   localparam logic [6:0] CODE_RESET = 7'h00;
   localparam logic [10:0] LIN_RESET = 11'h000;

   // ------------------------------------------------------------
   // start-up timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int ALIGN_TIME_US = 100;
   localparam int ALIGN_CYCLES = (ALIGN_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
      ALIGN_TIME_US * (CLK_HZ / 1_000_000);
   localparam int ALIGN_CNT_W = 12;

   // ------------------------------------------------------------
   // start-up enumerations
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MPCD_ROTOR_STILL,
      MPCD_ROTOR_FWD,
      MPCD_ROTOR_REV
   } mpcd_rotor_t;

   typedef enum logic [1:0]
   {
      MPCD_PHASE_U,
      MPCD_PHASE_V,
      MPCD_PHASE_W
   } mpcd_phase_t;

endpackage

// [verilog/mpcd_code_if.sv]
// mpcd_code_if: a coded value and its linear decode between decoder modules
// assumes: both ends share the core clock
`timescale 1ns/1ns
`default_nettype none
interface mpcd_code_if;
   logic [6:0] code;
   logic [10:0] linear;
   modport user (output code, input linear);
   modport conv (input code, output linear);
endinterface
`default_nettype wire

// [verilog/mpcd_code_conv.sv]
// mpcd_code_conv: registered pseudo-float decode, mantissa shifted by exponent
// assumes: code is stable from core logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module mpcd_code_conv
(
   input wire logic sys_clk,
   input wire logic rst,
   mpcd_code_if.conv port_c
);
   logic [10:0] linear_q;
   logic [10:0] linear_d;

   // mantissa bits 3..0 shifted left by exponent bits 6..4
   always_comb
   begin
      linear_d = 11'(port_c.code[mpcd_pkg::MANT_MSB:mpcd_pkg::MANT_LSB])
         << port_c.code[mpcd_pkg::EXP_MSB:mpcd_pkg::EXP_LSB];
   end

   // registered so the linear output is a flip-flop
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         linear_q <= mpcd_pkg::LIN_RESET;
      else
         linear_q <= linear_d;
   end

   assign port_c.linear = linear_q;
endmodule
`default_nettype wire

// [verilog/mpcd_top.sv]
// mpcd_top: decodes motor parameter codes and takes the first start-up decision
// assumes: codes held by the parameter registers, rotor class given by speed detect
//
// How it works
// - resistance code: low four bits shifted left by upper three; 0x0A=10, 0x18=16.
// - back-EMF linear value is low four bits shifted by upper three bits.
// - all-ones back-EMF code gives the largest value, 1920 steps.
// - back-EMF code one gives the smallest nonzero value, one step.
// - back-EMF code is a 7-bit phase-to-phase volts per velocity figure.
// - at start the rotor is stationary, forward or reverse, each own path.
// - stationary rotor: commutation state set to rotor position before acceleration.
// - stationary rotor offers two methods: position detect or forced alignment.
// - alignment energises one chosen phase until rotor lines up with it.
// - each resistance step is a fixed quantum; software divides before encoding.
`timescale 1ns/1ns
`default_nettype none
module mpcd_top
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [6:0] phase_resistance_code,
   input wire logic [6:0] bemf_constant_code,
   output logic [10:0] phase_resistance_linear,
   output logic [10:0] bemf_constant_linear,
   input wire logic start_req,
   input wire logic [1:0] rotor_class,
   input wire logic use_position_detect,
   input wire logic [1:0] align_phase_sel,
   input wire logic position_detect_done,
   input wire logic [2:0] detected_sector,
   output logic position_detect_start,
   output logic align_active,
   output logic [1:0] align_phase,
   output logic resync_start,
   output logic reverse_start,
   output logic accel_start,
   output logic [2:0] commutation_sector
);

   // ------------------------------------------------------------
   // code decoders
   // ------------------------------------------------------------
   mpcd_code_if res_c ();
   mpcd_code_if bemf_c ();

   assign res_c.code = phase_resistance_code;
   // bemf decode, fall out of shift: 0x7F->1920, 0x01->1
   assign bemf_c.code = bemf_constant_code;

   mpcd_code_conv u_res
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .port_c(res_c)
   );

   mpcd_code_conv u_bemf
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .port_c(bemf_c)
   );

   // linear steps passed through unscaled; quantum lives in software
   assign phase_resistance_linear = res_c.linear;
   assign bemf_constant_linear = bemf_c.linear;

   // ------------------------------------------------------------
   // start-up decision
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      MPCD_IDLE,
      MPCD_DETECT,
      MPCD_ALIGN,
      MPCD_DONE
   } mpcd_state_t;

   mpcd_state_t state_q;
   mpcd_state_t state_d;
   logic [11:0] align_cnt_q;
   logic align_end;
   logic [2:0] sector_q;
   logic [1:0] phase_q;

   // alignment dwell; fixed here since no register reaches it
   assign align_end = (align_cnt_q == 12'(mpcd_pkg::ALIGN_CYCLES - 1));

   // next state
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         MPCD_IDLE:
         begin
            if (start_req && rotor_class == 2'(mpcd_pkg::MPCD_ROTOR_STILL))
            begin
               if (use_position_detect)
                  state_d = MPCD_DETECT;
               else
                  state_d = MPCD_ALIGN;
            end
         end
         MPCD_DETECT:
            if (position_detect_done)
               state_d = MPCD_DONE;
         MPCD_ALIGN:
            if (align_end)
               state_d = MPCD_DONE;
         MPCD_DONE:
            state_d = MPCD_IDLE;
         default:
            state_d = MPCD_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         state_q <= MPCD_IDLE;
      else
         state_q <= state_d;
   end

   // align timer
   always_ff @(posedge sys_clk)
   begin
      if (rst || state_q != MPCD_ALIGN)
         align_cnt_q <= 12'h000;
      else
         align_cnt_q <= align_cnt_q + 12'h001;
   end

   // phase latched at entry so a mid-align change cannot jerk the rotor
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         phase_q <= 2'h0;
      else if (state_q == MPCD_IDLE && state_d == MPCD_ALIGN)
         phase_q <= (align_phase_sel == 2'h3) ? 2'h0 : align_phase_sel;
   end

   // commutation sector matches rotor before acceleration
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         sector_q <= 3'h0;
      else if (state_q == MPCD_DETECT && position_detect_done)
         sector_q <= detected_sector;
      else if (state_q == MPCD_ALIGN && align_end)
         sector_q <= {1'b0, phase_q} << 1; // sector lined up with aligned phase
   end

   // one chosen phase energised during align
   assign align_active = (state_q == MPCD_ALIGN);
   assign align_phase = phase_q;
   assign position_detect_start = (state_q == MPCD_IDLE) && (state_d == MPCD_DETECT);
   assign resync_start = start_req && (state_q == MPCD_IDLE) &&
      (rotor_class == 2'(mpcd_pkg::MPCD_ROTOR_FWD));
   assign reverse_start = start_req && (state_q == MPCD_IDLE) &&
      (rotor_class == 2'(mpcd_pkg::MPCD_ROTOR_REV));
   assign accel_start = (state_q == MPCD_DONE);
   assign commutation_sector = sector_q;

endmodule
`default_nettype wire

// [testbench/mpcd_properties.sv]
// mpcd_properties: timing checks on the decoder top ports
// assumes: bound into mpcd_top, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module mpcd_properties
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [6:0] phase_resistance_code,
   input wire logic [6:0] bemf_constant_code,
   input wire logic [10:0] phase_resistance_linear,
   input wire logic [10:0] bemf_constant_linear,
   input wire logic start_req,
   input wire logic [1:0] rotor_class,
   input wire logic use_position_detect,
   input wire logic [1:0] align_phase_sel,
   input wire logic position_detect_done,
   input wire logic [2:0] detected_sector,
   input wire logic position_detect_start,
   input wire logic align_active,
   input wire logic [1:0] align_phase,
   input wire logic resync_start,
   input wire logic reverse_start,
   input wire logic accel_start,
   input wire logic [2:0] commutation_sector
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic det_q;
   logic [10:0] dwell_q;
   // detector wait flag and align dwell count; a count of 0 hides a stuck align
   always_ff @(posedge sys_clk)
   begin
      det_q <= rst ? 1'b0 : (position_detect_start | (det_q & ~position_detect_done));
      dwell_q <= align_active ? dwell_q + 11'h001 : 11'h000;
   end
   sequence s_detect_end;
      det_q && position_detect_done;
   endsequence
   a_res_decode: assert property (1 |=> phase_resistance_linear ==
      ({7'h00, $past(phase_resistance_code[3:0])} << $past(phase_resistance_code[6:4])))
      else $error("resistance decode wrong");
   a_bemf_decode: assert property (1 |=> bemf_constant_linear ==
      ({7'h00, $past(bemf_constant_code[3:0])} << $past(bemf_constant_code[6:4])))
      else $error("bemf decode wrong");
   a_detect_go: assert property (position_detect_start |->
      start_req && rotor_class == 2'h0 && use_position_detect)
      else $error("detect start without cause");
   a_detect_done: assert property (s_detect_end |=>
      accel_start && commutation_sector == $past(detected_sector))
      else $error("detect end not followed by accel");
   a_align_dwell: assert property (!$past(rst) && $fell(align_active) |->
      dwell_q == 11'(mpcd_pkg::ALIGN_CYCLES) && accel_start &&
      commutation_sector == {align_phase, 1'b0})
      else $error("align dwell or sector wrong");
   a_align_phase: assert property ($rose(align_active) |-> align_phase ==
      (($past(align_phase_sel) == 2'h3) ? 2'h0 : $past(align_phase_sel)))
      else $error("align phase wrong");
   a_resync_cause: assert property (resync_start |->
      start_req && rotor_class == 2'h1) else $error("resync without cause");
   a_reverse_cause: assert property (reverse_start |->
      start_req && rotor_class == 2'h2) else $error("reverse without cause");
   a_accel_pulse: assert property (accel_start |=> !accel_start && !align_active)
      else $error("accel not one cycle");
endmodule
bind mpcd_top mpcd_properties chk (.*);
`default_nettype wire

// [testbench/mpcd_top_tb.sv]
// mpcd_top_tb: table, random and start path checks of the decoder
// assumes: package, interface, design and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module mpcd_top_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [6:0] phase_resistance_code = 7'h00;
   logic [6:0] bemf_constant_code = 7'h00;
   logic start_req = 1'b0;
   logic [1:0] rotor_class = 2'h0;
   logic use_position_detect = 1'b0;
   logic [1:0] align_phase_sel = 2'h0;
   logic position_detect_done = 1'b0;
   logic [2:0] detected_sector = 3'h0;
   logic [10:0] phase_resistance_linear, bemf_constant_linear;
   logic position_detect_start, align_active, resync_start, reverse_start, accel_start;
   logic [1:0] align_phase;
   logic [2:0] commutation_sector;
   logic [6:0] codes [4] = '{7'h0a, 7'h18, 7'h7f, 7'h01};
   logic [10:0] lins [4] = '{11'h00a, 11'h010, 11'h780, 11'h001};
   int num_errors = 0;
   int checks_done = 0;
   int n;
   int k;
   mpcd_top dut (.*);
   // 100 ns period core clock
   always #50 sys_clk = ~sys_clk;
   function automatic logic [10:0] decode(input logic [6:0] c);
      return {7'h00, c[3:0]} << c[6:4];
   endfunction
   // software side: a nonzero exponent always carries a mantissa of 8 to 15
   function automatic logic [6:0] norm_code(input logic [31:0] r);
      return (r[6:4] == 3'h0) ? {3'h0, r[3:0]} : {r[6:4], 1'b1, r[2:0]};
   endfunction
   task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // request one start decision; the combinational strobes are read before the edge
   task automatic go(input logic [1:0] cls, input logic det, input logic [1:0] ph);
      rotor_class = cls;
      use_position_detect = det;
      align_phase_sel = ph;
      start_req = 1'b1;
      #1;
      chk("resync", {10'h000, cls == 2'h1}, {10'h000, resync_start});
      chk("reverse", {10'h000, cls == 2'h2}, {10'h000, reverse_start});
      chk("detect_go", {10'h000, cls == 2'h0 && det}, {10'h000, position_detect_start});
      @(negedge sys_clk);
      // drop the request and let an edge pass, so a following call never retoggles it
      start_req = 1'b0;
      @(negedge sys_clk);
   endtask
   // main sequence: decode table, random codes, then each start path
   initial
   begin
      void'($urandom(32'h9261));
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      for (n = 0; n < 52; n++)
      begin
         // register a resistance, register b back-EMF
         phase_resistance_code = (n < 4) ? codes[n] : norm_code($urandom);
         bemf_constant_code = (n < 4) ? codes[3 - n] : norm_code($urandom);
         @(negedge sys_clk);
         chk("res_lin", (n < 4) ? lins[n] : decode(phase_resistance_code), phase_resistance_linear);
         chk("bemf_lin", (n < 4) ? lins[3 - n] : decode(bemf_constant_code), bemf_constant_linear);
      end
      go(2'h1, 1'b0, 2'h0);
      go(2'h2, 1'b0, 2'h0);
      go(2'h3, 1'b1, 2'h0);
      go(2'h0, 1'b1, 2'h0);
      repeat (3) @(negedge sys_clk);
      detected_sector = 3'($urandom);
      position_detect_done = 1'b1;
      @(negedge sys_clk);
      position_detect_done = 1'b0;
      chk("accel", 11'h001, {10'h000, accel_start});
      chk("sector", {8'h00, detected_sector}, {8'h00, commutation_sector});
      // mid-run reset one cycle after accel, so the detect checks are not disabled
      @(negedge sys_clk);
      rst = 1'b1;
      @(negedge sys_clk);
      chk("rst_res_lin", mpcd_pkg::LIN_RESET, phase_resistance_linear);
      chk("rst_accel", 11'h000, {10'h000, accel_start});
      chk("rst_sector", 11'h000, {8'h00, commutation_sector});
      rst = 1'b0;
      for (n = 0; n < 4; n++)
      begin
         @(negedge sys_clk);
         go(2'h0, 1'b0, n[1:0]);
         chk("phase", {9'h000, (n == 3) ? 2'h0 : n[1:0]}, {9'h000, align_phase});
         // k counts edges since the start edge; go has already spent two of them
         for (k = 2; accel_start !== 1'b1 && k < 1100; k++)
            @(negedge sys_clk);
         if (k >= 1100)
         begin
            num_errors++;
            break;
         end
         chk("dwell", 11'(mpcd_pkg::ALIGN_CYCLES + 1), 11'(k));
         chk("align_sector", {8'h00, (n == 3) ? 3'h0 : 3'(n * 2)}, {8'h00, commutation_sector});
      end
      close_out();
   end
endmodule
`default_nettype wire
